// File: seerd_pkg.sv
// Shared constants and types for the serial memory read path
package seerd_pkg;
  localparam int          SEERD_AW         = 8;
  localparam int          SEERD_DW         = 8;
  localparam int          SEERD_DEPTH      = 256;
  localparam logic [6:0]  SEERD_DEV_ADDR   = 7'h50;
  localparam logic        SEERD_RW_READ    = 1'b1;
  localparam logic        SEERD_RW_WRITE   = 1'b0;
  localparam logic [7:0]  SEERD_ADDR_RST   = 8'h00;
  localparam logic [3:0]  SEERD_BIT_LAST   = 4'h7;
  localparam logic [3:0]  SEERD_BIT_RST    = 4'h0;
  localparam logic [7:0]  SEERD_BYTE_RST   = 8'h00;
  // Master side timing
  localparam real         SEERD_CLK_MHZ    = 125.0;
  localparam real         SEERD_QPHASE_NS  = 1250.0;
  localparam int          SEERD_QPHASE_CYC =
    int'(SEERD_QPHASE_NS * SEERD_CLK_MHZ / 1000.0);
  localparam logic [11:0] SEERD_QPHASE_W   = 12'(SEERD_QPHASE_CYC);

  typedef enum logic [2:0] {
    SEERD_S_IDLE  = 3'b000,
    SEERD_S_ADDR  = 3'b001,
    SEERD_S_AACK  = 3'b011,
    SEERD_S_WORD  = 3'b010,
    SEERD_S_WACK  = 3'b110,
    SEERD_S_SEND  = 3'b111,
    SEERD_S_MACK  = 3'b101,
    SEERD_S_SKIP  = 3'b100
  } seerd_dev_st_t;

  typedef enum logic [3:0] {
    SEERD_M_IDLE  = 4'b0000,
    SEERD_M_START = 4'b0001,
    SEERD_M_BIT   = 4'b0011,
    SEERD_M_ACK   = 4'b0010,
    SEERD_M_RBIT  = 4'b0110,
    SEERD_M_MACK  = 4'b0111,
    SEERD_M_RSTRT = 4'b0101,
    SEERD_M_STOP  = 4'b0100,
    SEERD_M_DONE  = 4'b1100
  } seerd_mst_st_t;

  function automatic logic [7:0] seerd_inc(input logic [7:0] a);
    return a + 8'h01;
  endfunction : seerd_inc
endpackage : seerd_pkg

// File: seerd_if.sv
// Two-wire bus between master and memory device
`timescale 1ns/1ps
interface seerd_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open drain wired-and with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport mst (input scl, input sda, output scl_o, output scl_oe,
               output sda_m_o, output sda_m_oe);
endinterface : seerd_if

// File: seerd_dev.sv
// Memory device end: two-wire slave with read path and address counter
//
// Overview of operation
// - Read starts as write, direction bit one
// - Address counter advances after every access; write data bytes load it instead
// - Ack read address, send byte MSB first
// - Master stops after eighth bit, no ack
// - Random read: dummy write, repeated start
// - Repeated start read returns loaded location
// - Master ack: increment, send next byte
// - Counter wraps 255 to 0 until stop
// - Master ends by withholding ack then stop
// - After no ack, release SDA high
// - SDA stable while SCL high
// - Falling SDA, SCL high: start anywhere
// - Rising SDA, SCL high: stop, idle
// - Master starts only on idle bus
// - Ninth clock per byte, transmitter releases
// - Acknowledge every byte received when addressed
// - Acknowledger holds SDA low whole pulse
// - No limit on bytes per transfer
// - Address LSB selects read or write
// - Byte after write address loads counter
`timescale 1ns/1ps
module seerd_dev #(
  parameter logic [6:0] DEV_ADDR = seerd_pkg::SEERD_DEV_ADDR
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  // Bus side
  seerd_if.dev                                bus,
  // Memory load port
  input  wire logic                           ld_en,
  input  wire logic [seerd_pkg::SEERD_AW-1:0] ld_addr,
  input  wire logic [seerd_pkg::SEERD_DW-1:0] ld_data,
  // Status
  output logic      [seerd_pkg::SEERD_AW-1:0] addr_ptr,
  output logic                                busy
);
  import seerd_pkg::*;

  typedef struct packed {
    logic [1:0]     scl_sy;
    logic [1:0]     sda_sy;
    logic           scl_p;
    logic           sda_p;
    seerd_dev_st_t  st;
    logic [3:0]     bitn;
    logic [7:0]     sh;
    logic [7:0]     ctr;
    logic           rd;
    logic           sda_oe;
    logic           busy;
  } seerd_dev_s_t;

  seerd_dev_s_t q, d;
  logic [SEERD_DW-1:0] mem [SEERD_DEPTH];
  logic [SEERD_DW-1:0] mem_rd;
  logic                addr_hit;

  // Settled line levels and the events judged from them
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

  // Backdoor preload; bus write data is acked but never stored
  always_ff @(posedge clock) begin
    if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
  end

  // Only second stage and its delayed copy are looked at
  assign scl_s    = q.scl_sy[1];
  assign sda_s    = q.sda_sy[1];
  assign scl_rise = scl_s & ~q.scl_p;
  assign scl_fall = ~scl_s & q.scl_p;
  assign start_c  = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_c   = scl_s & q.scl_p & ~q.sda_p & sda_s;

  // Byte to send always comes from the counter's location
  assign mem_rd   = mem[q.ctr];
  assign addr_hit = q.sh[7:1] == DEV_ADDR;

  always_comb begin
    d        = q;
    d.scl_sy = {q.scl_sy[0], bus.scl};
    d.sda_sy = {q.sda_sy[0], bus.sda};
    d.scl_p  = scl_s;
    d.sda_p  = sda_s;
    if (start_c) begin
      d.st     = SEERD_S_ADDR;
      d.bitn   = SEERD_BIT_RST;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      // Stop ends any transfer, wherever it stands
      d.st     = SEERD_S_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Received bits are taken on the settled scl rise
      case (q.st)
        SEERD_S_ADDR, SEERD_S_WORD: begin
          d.sh   = {q.sh[6:0], sda_s};
          d.bitn = q.bitn + 4'h1;
        end
        SEERD_S_MACK: begin
          // Master ack continues, nack releases and waits for stop
          d.st = sda_s ? SEERD_S_SKIP : SEERD_S_MACK;
        end
        default: d.st = q.st;
      endcase
    end else if (scl_fall) begin
      // All that the device drives moves just after scl falls
      case (q.st)
        SEERD_S_ADDR: begin
          if (q.bitn == 4'h8) begin
            if (addr_hit) begin
              d.st     = SEERD_S_AACK;
              d.rd     = q.sh[0] == SEERD_RW_READ;
              d.sda_oe = 1'b1;
            end else begin
              // Other address: keep off the bus until start or stop
              d.st = SEERD_S_SKIP;
            end
          end
        end
        SEERD_S_AACK: begin
          d.bitn = SEERD_BIT_RST;
          if (q.rd) begin
            // Byte at counter, MSB first
            d.st     = SEERD_S_SEND;
            d.sh     = mem_rd;
            d.sda_oe = ~mem_rd[7];
            d.ctr    = seerd_inc(q.ctr);
          end else begin
            d.st     = SEERD_S_WORD;
            d.sda_oe = 1'b0;
          end
        end
        SEERD_S_WORD: begin
          if (q.bitn == 4'h8) begin
            d.ctr    = q.sh;
            d.st     = SEERD_S_WACK;
            d.sda_oe = 1'b1;
          end
        end
        SEERD_S_WACK: begin
          // Data bytes of writes are acked but not stored here
          d.st     = SEERD_S_WORD;
          d.bitn   = SEERD_BIT_RST;
          d.sda_oe = 1'b0;
          d.ctr    = q.ctr;
        end
        SEERD_S_SEND: begin
          if (q.bitn == SEERD_BIT_LAST) begin
            // Eighth bit out: let go of SDA for the ack clock
            d.st     = SEERD_S_MACK;
            d.sda_oe = 1'b0;
          end else begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
            d.bitn   = q.bitn + 4'h1;
          end
        end
        SEERD_S_MACK: begin
          // Wrap from 255 to 0 is natural 8-bit overflow
          d.st     = SEERD_S_SEND;
          d.bitn   = SEERD_BIT_RST;
          d.sh     = mem_rd;
          d.sda_oe = ~mem_rd[7];
          d.ctr    = seerd_inc(q.ctr);
        end
        SEERD_S_SKIP: begin
          // Nack seen or other address: SDA left high for the master's stop
          d.sda_oe = 1'b0;
        end
        default: d.st = q.st;
      endcase
    end
    // Registered so the status pin comes straight from a flop
    d.busy = d.st != SEERD_S_IDLE;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // Lines read as released, so no false start after reset
      q.scl_sy <= 2'b11;
      q.sda_sy <= 2'b11;
      q.scl_p  <= 1'b1;
      q.sda_p  <= 1'b1;
      q.st     <= SEERD_S_IDLE;
      q.bitn   <= SEERD_BIT_RST;
      q.sh     <= SEERD_BYTE_RST;
      q.ctr    <= SEERD_ADDR_RST;
      q.rd     <= 1'b0;
      q.sda_oe <= 1'b0;
      q.busy   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Open drain: only the enable moves, the level stays low
  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = q.sda_oe;
  assign addr_ptr     = q.ctr;
  assign busy         = q.busy;
endmodule : seerd_dev

// File: seerd_mst.sv
// Master end: issues current, random and sequential reads
`timescale 1ns/1ps
module seerd_mst #(
  parameter logic [6:0] DEV_ADDR = seerd_pkg::SEERD_DEV_ADDR
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bus side
  seerd_if.mst            bus,
  // Request
  input  wire logic       req,
  input  wire logic       req_random,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_len,
  // Answer
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack_err,
  output logic            idle
);
  import seerd_pkg::*;

  typedef struct packed {
    seerd_mst_st_t st;
    logic [11:0]   tm;
    logic [1:0]    ph;
    logic [3:0]    bitn;
    logic [7:0]    sh;
    logic [7:0]    left;
    logic [1:0]    step;
    logic          one;
    logic [7:0]    wa;
    logic          scl_oe;
    logic          sda_oe;
    logic          rd_valid;
    logic [7:0]    rd_data;
    logic          done;
    logic          nack;
    logic          is_idle;
  } seerd_mst_s_t;

  seerd_mst_s_t q, d;
  logic tick;
  logic rw_bit;

  assign tick   = q.tm == 12'h000;
  // Address byte direction: read at step 2, after the word address or from the start of a current read
  assign rw_bit = q.step == 2'b10 ? SEERD_RW_READ : SEERD_RW_WRITE;

  always_comb begin
    d          = q;
    d.rd_valid = 1'b0;
    d.done     = 1'b0;
    d.tm       = tick ? SEERD_QPHASE_W : q.tm - 12'h001;
    if (q.st == SEERD_M_IDLE) begin
      d.ph = 2'b00;
      // Start only with both lines high
      if (req && bus.scl && bus.sda) begin
        d.st   = SEERD_M_START;
        // Lone byte reads end without a ninth clock
        d.one  = req_len == 8'h01;
        d.wa   = req_addr;
        d.left = req_len;
        d.step = req_random ? 2'b00 : 2'b10;
        d.nack = 1'b0;
      end
    end else if (tick) begin
      d.ph = q.ph + 2'b01;
      case (q.st)
        SEERD_M_START, SEERD_M_RSTRT: begin
          // SDA falls with SCL high
          case (q.ph)
            2'b00: begin
              d.scl_oe = 1'b0;
              d.sda_oe = 1'b0;
            end
            2'b01: d.sda_oe = 1'b1;
            2'b10: d.scl_oe = 1'b1;
            default: begin
              d.st   = SEERD_M_BIT;
              d.bitn = SEERD_BIT_RST;
              d.sh   = {DEV_ADDR, rw_bit};
              d.ph   = 2'b00;
            end
          endcase
        end
        SEERD_M_BIT, SEERD_M_ACK, SEERD_M_RBIT, SEERD_M_MACK: begin
          case (q.ph)
            2'b00: begin
              // Data changes only while SCL low
              if (q.st == SEERD_M_BIT) begin
                d.sda_oe = ~q.sh[7];
              end else if (q.st == SEERD_M_MACK) begin
                d.sda_oe = q.left != 8'h00;
              end else begin
                d.sda_oe = 1'b0;
              end
            end
            2'b01: d.scl_oe = 1'b0;
            2'b10: begin
              if (q.st == SEERD_M_ACK && bus.sda) d.nack = 1'b1;
              if (q.st == SEERD_M_RBIT) d.sh = {q.sh[6:0], bus.sda};
            end
            default: begin
              d.scl_oe = 1'b1;
              d.bitn   = q.bitn + 4'h1;
              if (q.st == SEERD_M_BIT) d.sh = {q.sh[6:0], 1'b0};
              case (q.st)
                SEERD_M_BIT:
                  if (q.bitn == SEERD_BIT_LAST) d.st = SEERD_M_ACK;
                SEERD_M_ACK: begin
                  d.bitn = SEERD_BIT_RST;
                  if (q.nack) d.st = SEERD_M_STOP;
                  else if (q.step == 2'b00) begin
                    d.st = SEERD_M_BIT;
                    d.sh = q.wa;
                    d.step = 2'b01;
                  end else if (q.step == 2'b01) begin
                    d.st = SEERD_M_RSTRT;
                    d.step = 2'b10;
                  end else d.st = SEERD_M_RBIT;
                end
                SEERD_M_RBIT:
                  if (q.bitn == SEERD_BIT_LAST) begin
                    d.rd_valid = 1'b1;
                    d.rd_data  = q.sh;
                    d.left     = q.left - 8'h01;
                    d.bitn     = SEERD_BIT_RST;
                    d.st       = q.one ? SEERD_M_STOP : SEERD_M_MACK;
                  end
                default: begin
                  d.bitn = SEERD_BIT_RST;
                  d.st   = q.sda_oe ? SEERD_M_RBIT : SEERD_M_STOP;
                end
              endcase
            end
          endcase
        end
        SEERD_M_STOP: begin
          // SDA rises with SCL high
          case (q.ph)
            2'b00: d.sda_oe = 1'b1;
            2'b01: d.scl_oe = 1'b0;
            2'b10: d.sda_oe = 1'b0;
            default: d.st = SEERD_M_DONE;
          endcase
        end
        SEERD_M_DONE: begin
          d.done = 1'b1;
          d.st   = SEERD_M_IDLE;
        end
        default: d.st = SEERD_M_IDLE;
      endcase
    end
    d.is_idle = d.st == SEERD_M_IDLE;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q.st       <= SEERD_M_IDLE;
      q.tm       <= SEERD_QPHASE_W;
      q.ph       <= 2'b00;
      q.bitn     <= SEERD_BIT_RST;
      q.sh       <= SEERD_BYTE_RST;
      q.left     <= SEERD_BYTE_RST;
      q.step     <= 2'b00;
      q.one      <= 1'b0;
      q.wa       <= SEERD_ADDR_RST;
      q.scl_oe   <= 1'b0;
      q.sda_oe   <= 1'b0;
      q.rd_valid <= 1'b0;
      q.rd_data  <= SEERD_BYTE_RST;
      q.done     <= 1'b0;
      q.nack     <= 1'b0;
      q.is_idle  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = q.scl_oe;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = q.sda_oe;
  assign rd_valid     = q.rd_valid;
  assign rd_data      = q.rd_data;
  assign done         = q.done;
  assign nack_err     = q.nack;
  assign idle         = q.is_idle;
endmodule : seerd_mst

// File: seerd_sva.sv
// Bus checker for the two-wire read path
`timescale 1ns/1ps
module seerd_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus lines
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_dev_ack;
    sda_s_oe && $rose(scl);
  endsequence
  sequence s_low_held;
    (sda_s_oe && !sda)[*8];
  endsequence
  sequence s_dev_quiet;
    (!sda_s_oe)[*8];
  endsequence

  // Device moves only well after scl has fallen
  property p_dev_change;
    $changed(sda_s_oe) |-> !scl && !$past(scl, 2);
  endproperty
  property p_dev_settle;
    $rose(scl) |-> sda_s_oe == $past(sda_s_oe, 8);
  endproperty
  property p_no_contend;
    $rose(scl) |-> !(sda_m_oe && sda_s_oe);
  endproperty

  chk_dev_change: assert property (p_dev_change)
    else $error("device moved sda near scl high");
  chk_dev_settle: assert property (p_dev_settle)
    else $error("device sda not settled before scl rise");
  chk_ack_hold: assert property (s_dev_ack |-> s_low_held)
    else $error("device low level not held in scl high");
  chk_no_contend: assert property (p_no_contend)
    else $error("both ends pull sda at scl rise");
  chk_start_quiet: assert property (s_start |=> s_dev_quiet)
    else $error("device drives sda right after start");
  chk_stop_quiet: assert property (s_stop |=> s_dev_quiet)
    else $error("device drives sda right after stop");
  chk_scl_low_min: assert property ($rose(scl_oe) |=> scl_oe[*8])
    else $error("scl low phase too short");
  chk_scl_high_min: assert property ($rose(scl) |=> scl[*8])
    else $error("scl high phase too short");
  // Open drain: the device never drives a high level
  chk_open_drain: assert property (sda_s_oe |-> sda_s_o == 1'b0)
    else $error("device drives sda high");
endmodule : seerd_sva

// File: serial_eeprom_read_path_tb.sv
// Testbench: master and device joined on one bus
`timescale 1ns/1ps
module serial_eeprom_read_path_tb;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       ld_en = 1'b0;
  logic [7:0] ld_addr = 8'h00;
  logic [7:0] ld_data = 8'h00;
  logic       req = 1'b0;
  logic       req_random = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_len = 8'h01;
  logic [7:0] addr_ptr;
  logic [7:0] rd_data;
  logic       busy;
  logic       rd_valid;
  logic       done;
  logic       nack_err;
  logic       idle;
  int         miscompares = 0;
  int         n_checks = 0;

  seerd_if sbus ();
  seerd_dev u_seerd_dev (.clock(clock), .rst_n(rst_n), .bus(sbus),
    .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .addr_ptr(addr_ptr), .busy(busy));
  seerd_mst u_seerd_mst (.clock(clock), .rst_n(rst_n), .bus(sbus),
    .req(req), .req_random(req_random), .req_addr(req_addr),
    .req_len(req_len), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .nack_err(nack_err), .idle(idle));
  seerd_sva u_seerd_sva (.clock(clock), .rst_n(rst_n),
    .scl_oe(sbus.scl_oe), .sda_m_oe(sbus.sda_m_oe),
    .sda_s_o(sbus.sda_s_o), .sda_s_oe(sbus.sda_s_oe),
    .scl(sbus.scl), .sda(sbus.sda));

  always #4 clock = ~clock;

  // Memory image: distinct bytes so a wrong address shows
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction : pat

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // One master transfer; start is where the device should begin
  task automatic run_read(input logic rnd, input logic [7:0] a,
                          input logic [7:0] n, input logic [7:0] start);
    logic [7:0] e;
    int         got;
    int         t;
    e = start;
    got = 0;
    t = 0;
    @(posedge clock);
    req        <= 1'b1;
    req_random <= rnd;
    req_addr   <= a;
    req_len    <= n;
    @(negedge clock);
    while (idle !== 1'b0 && t < 2000) begin
      @(negedge clock);
      t++;
    end
    @(posedge clock);
    req <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 60000) begin
      @(negedge clock);
      t++;
      if (rd_valid === 1'b1) begin
        chk(rd_data, pat(e));
        e = e + 8'h01;
        got++;
      end
    end
    chk({7'h00, done}, 8'h01);
    chk(8'(got), n);
    chk({7'h00, nack_err}, 8'h00);
    chk(addr_ptr, start + n);
    repeat (400) @(negedge clock);
    chk({6'h00, sbus.scl, sbus.sda}, 8'h03);
  endtask : run_read

  task automatic test_random;
    run_read(1'b1, 8'h10, 8'h01, 8'h10);
    $display("test_random done");
  endtask : test_random

  task automatic test_current;
    run_read(1'b0, 8'h00, 8'h01, 8'h11);
    $display("test_current done");
  endtask : test_current

  // Crosses the top of memory to check the wrap
  task automatic test_seq_wrap;
    run_read(1'b1, 8'hfe, 8'h04, 8'hfe);
    $display("test_seq_wrap done");
  endtask : test_seq_wrap

  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk({6'h00, idle, busy}, 8'h02);
    @(posedge clock);
    rst_n <= 1'b1;
    ld_en <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      ld_addr <= 8'(i);
      ld_data <= pat(8'(i));
      @(posedge clock);
    end
    ld_en <= 1'b0;
    test_random();
    test_current();
    test_seq_wrap();
    finish_test();
  end

  // The three reads take some 80000 cycles; guard a little beyond
  initial begin
    #(8 * 98000);
    miscompares++;
    finish_test();
  end
endmodule : serial_eeprom_read_path_tb
